// ---- dv/lsb_core_bench.sv ----
// Purpose: Directed bench for lsb_core
// Assumes: Branch offsets of either sign
// Notes:   p tracks the pc of the next word offered
`include "lsb_regs.vh"
`default_nettype none
module lsb_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, reset_n_i, ce_i, instr_valid_i;
  logic [15:0] instr_i;
  logic [31:0] ra_data_i, rb_data_i, p, b;
  wire  [4:0]  ra_index_o, wr_index_o;
  wire         wr_en_o, illegal_o;
  wire  [31:0] wr_data_o, pc_o;
  wire  [3:0]  flags_o;
  wire  [10:0] prefix_o;
  int          mismatches, check_count;
  lsb_core u_lsb_core (.clk_i, .reset_n_i, .ce_i, .instr_valid_i, .instr_i, .ra_data_i, .rb_data_i,
    .ra_index_o, .wr_en_o, .wr_index_o, .wr_data_o, .flags_o, .pc_o, .prefix_o, .illegal_o);
  function automatic logic [15:0] enc(input logic [5:0] op, input logic [4:0] f);
    return {op, f, 5'h03};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input logic [15:0] ins, input logic [31:0] a, input logic [31:0] bv);
    instr_i <= ins;
    ra_data_i <= a;
    rb_data_i <= bv;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    #1;
    p = p + 32'h2;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #50000;
    mismatches++;
    wrap_up;
  end
  initial begin
    {reset_n_i, instr_valid_i, instr_i, ra_data_i, rb_data_i, p} = '0;
    ce_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk({wr_en_o, flags_o, prefix_o, illegal_o, pc_o}, 0);
    reset_n_i <= 1'b1;
    step(enc(`LSB_OP6_ADD_IMMEDIATE, 5'h02), 32'hfffffffe, 0);
    chk(wr_data_o, 0);
    chk(flags_o, 4'h3);
    step(enc(`LSB_OP6_AND_REG, 5'h07), 32'hf0f0ff00, 32'h80000ff0);
    chk({wr_index_o, wr_data_o}, {5'h03, 32'h80000f00});
    chk(ra_index_o, 5'h03);
    chk(flags_o, 4'h9);
    step({`LSB_OP5_PREFIX, 11'h7ff}, 0, 0);
    chk(prefix_o, 11'h7ff);
    step(enc(`LSB_OP6_AND_IMM, 5'h1f), 32'h12345678, 32'hffffffff);
    chk(wr_data_o, 32'h00005678);
    chk(prefix_o, 0);
    step(enc(`LSB_OP6_AND_NOT_REG, 5'h01), 32'hffffffff, 32'h0f0f0000);
    chk(wr_data_o, 32'hf0f0ffff);
    step({`LSB_OP5_PREFIX, 11'h001}, 0, 0);
    step(enc(`LSB_OP6_AND_NOT_IMM, 5'h00), 32'hffffffff, 0);
    chk(wr_data_o, 32'hffffffdf);
    step(enc(`LSB_OP6_ASR_REG, 5'h01), 32'h80000010, 32'h4);
    chk({flags_o, wr_data_o}, {4'h9, 32'hf8000001});
    step(enc(`LSB_OP6_ASR_IMM, 5'h1f), 32'h80000000, 0);
    chk(wr_data_o, 32'hffffffff);
    step(enc(`LSB_OP6_ASR_IMM, 5'h1f), 32'h7fffffff, 0);
    chk(wr_data_o, 0);
    for (int i = 0; i < 32; i += 31) begin
      step(enc(`LSB_OP6_BIT_GENERATE, i[4:0]), 0, 0);
      chk({flags_o, wr_data_o}, {4'h9, 32'h1 << i});
    end
    step(enc(`LSB_OP6_COMPARE_REG, 5'h01), 32'h5, 32'h5);
    chk({wr_en_o, flags_o}, 5'h02);
    step(enc(`LSB_OP6_COMPARE_REG, 5'h01), 32'h1, 32'h2);
    chk({wr_en_o, flags_o}, 5'h09);
    step(enc(`LSB_OP6_COMPARE_REG, 5'h01), 32'h80000000, 32'h1);
    chk({wr_en_o, flags_o}, 5'h04);
    step({`LSB_OP5_PREFIX, 11'h001}, 0, 0);
    step(enc(`LSB_OP6_COMPARE_IMM, 5'h00), 32'h20, 0);
    chk({wr_en_o, flags_o}, 5'h02);
    b = p;
    step({`LSB_OP5_BRANCH, 11'h005}, 0, 0);
    chk(pc_o, b + 32'h2);
    step(enc(`LSB_OP6_BIT_GENERATE, 5'h04), 0, 0);
    chk(wr_data_o, 32'h10);
    p = b + 32'hc;
    chk(pc_o, p);
    b = p;
    step({`LSB_OP5_BRANCH_SUB, 11'h003}, 0, 0);
    chk({wr_en_o, wr_index_o, wr_data_o}, {1'b1, `LSB_LINK_INDEX, (b + 32'h4) >> 1});
    step(enc(`LSB_OP6_AND_REG, 5'h01), 32'h3, 32'h6);
    chk(wr_data_o, 32'h2);
    p = b + 32'h8;
    chk(pc_o, p);
    b = p;
    step({`LSB_OP11_CALL, 5'h03}, 32'h00000800, 0);
    chk(wr_data_o, (b + 32'h4) >> 1);
    step(enc(`LSB_OP6_BIT_GENERATE, 5'h02), 0, 0);
    chk(pc_o, 32'h1000);
    // Clock enable low must freeze pc and data
    ce_i <= 1'b0;
    step(enc(`LSB_OP6_BIT_GENERATE, 5'h1f), 0, 0);
    chk({pc_o, wr_data_o}, {32'h1000, 32'h4});
    ce_i <= 1'b1;
    // Backward branch: bit 10 carries the offset sign
    step({`LSB_OP5_BRANCH, 11'h7fd}, 0, 0);
    chk(pc_o, 32'h1002);
    step(enc(`LSB_OP6_BIT_GENERATE, 5'h03), 0, 0);
    chk({pc_o, wr_data_o}, {32'h0ffc, 32'h8});
    // A word outside this unit raises illegal_o, writes no register, keeps the flags and advances the pc
    step(16'h0000, 0, 0);
    chk({illegal_o, wr_en_o, pc_o}, {1'b1, 1'b0, 32'h0ffe});
    instr_valid_i <= 1'b0;
    @(posedge clk_i);
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- dv/lsb_core_chk.sv ----
// Purpose: Port assertions for lsb_core
// Assumes: One clock, synchronous active-low reset
// Notes:   Slot and prefix state rebuilt from the port history
`include "lsb_regs.vh"
`default_nettype none
module lsb_core_chk (
  input wire logic        clk_i,         // Clock
  input wire logic        reset_n_i,     // Reset
  input wire logic        ce_i,          // Enable
  input wire logic        instr_valid_i, // Valid
  input wire logic [15:0] instr_i,       // Word
  input wire logic [31:0] ra_data_i,     // Operand a
  input wire logic [31:0] rb_data_i,     // Operand b
  input wire logic [4:0]  ra_index_o,    // Echo
  input wire logic        wr_en_o,       // Write
  input wire logic [4:0]  wr_index_o,    // Index
  input wire logic [31:0] wr_data_o,     // Data
  input wire logic [3:0]  flags_o,       // Flags
  input wire logic [31:0] pc_o,          // Pc
  input wire logic [10:0] prefix_o,      // Prefix
  input wire logic        illegal_o      // Illegal
);
  logic pend;
  logic slot;
  wire logic       tk   = reset_n_i & ce_i & instr_valid_i;
  wire logic [5:0] op   = instr_i[15:10];
  wire logic       prefix_op  = instr_i[15:11] == `LSB_OP5_PREFIX;
  wire logic       call = instr_i[15:5] == `LSB_OP11_CALL;
  wire logic       br   = instr_i[15:11] == `LSB_OP5_BRANCH;
  wire logic       branch_subroutine_op  = instr_i[15:11] == `LSB_OP5_BRANCH_SUB;
  // A transfer inside a slot is ignored, so slot state gates it
  wire logic xfer = tk & !slot & (br | branch_subroutine_op | call);
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend <= 1'b0;
      slot <= 1'b0;
    end else if (tk) begin
      pend <= prefix_op;
      slot <= xfer;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_add_imm_flags: assert property (tk & !pend & op == `LSB_OP6_ADD_IMMEDIATE |=> wr_en_o &&
    {flags_o[0], wr_data_o} == {1'b0, $past(ra_data_i)} + $past(instr_i[9:5]) && flags_o[1] == (wr_data_o == 32'h0))
    else $error("add immediate result or flags wrong");
  a_and_reg_flags: assert property (tk & !pend & op == `LSB_OP6_AND_REG |=>
    wr_data_o == $past(ra_data_i & rb_data_i) &&
    flags_o == {wr_data_o[31], $past(flags_o[2]), wr_data_o == 32'h0, $past(flags_o[0])})
    else $error("and result or flags wrong");
  a_and_not_const: assert property (tk & pend & op == `LSB_OP6_AND_NOT_IMM |=>
    wr_data_o == ($past(ra_data_i) & ~{16'h0, $past(prefix_o), $past(instr_i[9:5])}))
    else $error("and-not constant result wrong");
  a_asr_imm_fill: assert property (tk & op == `LSB_OP6_ASR_IMM |=> $stable(flags_o) &&
    $signed(wr_data_o) == ($signed($past(ra_data_i)) >>> $past(instr_i[9:5])))
    else $error("immediate shift wrong");
  a_bit_gen_value: assert property (tk & op == `LSB_OP6_BIT_GENERATE |=>
    wr_data_o == 32'h1 << $past(instr_i[9:5]) && $stable(flags_o))
    else $error("bit generate wrong");
  a_cmp_no_write: assert property (tk & !pend & op == `LSB_OP6_COMPARE_REG |=> !wr_en_o &&
    flags_o[1] == ($past(ra_data_i) == $past(rb_data_i)) && flags_o[0] == ($past(ra_data_i) < $past(rb_data_i)))
    else $error("compare flags or write wrong");
  a_branch_target: assert property (xfer & br ##1 tk |=>
    pc_o == $past(pc_o, 2) + (({{21{$past(instr_i[10], 2)}}, $past(instr_i[10:0], 2)} + 32'h1) << 1))
    else $error("branch target wrong");
  a_link_write: assert property (xfer & !br |=> wr_en_o && wr_index_o == `LSB_LINK_INDEX &&
    wr_data_o == ($past(pc_o) + 32'h4) >> 1 && pc_o == $past(pc_o) + 32'h2)
    else $error("link write wrong");
  a_call_target: assert property (xfer & call ##1 tk |=> pc_o == $past(ra_data_i, 2) << 1)
    else $error("call target wrong");
  a_prefix_clear: assert property (tk & pend & !prefix_op |=> prefix_o == 11'h000)
    else $error("prefix not cleared");
  c_branch: cover property (xfer & br);
  c_call: cover property (xfer & call);
  c_prefixed: cover property (tk & pend & !prefix_op);
endmodule
bind lsb_core lsb_core_chk u_lsb_core_chk (.clk_i, .reset_n_i, .ce_i, .instr_valid_i, .instr_i, .ra_data_i,
  .rb_data_i, .ra_index_o, .wr_en_o, .wr_index_o, .wr_data_o, .flags_o, .pc_o, .prefix_o, .illegal_o);
`default_nettype wire

// ---- rtl/lsb_alu.v ----
// Purpose: Result and flag datapath for the logic, shift and compare ops
// Assumes: Purely combinational
// Notes:   Flag writes are qualified by the caller's enables
`include "lsb_regs.vh"
`default_nettype none
module lsb_alu (
  input  wire [31:0] a_i,        // First register operand
  input  wire [31:0] b_i,        // Second operand, register or constant
  input  wire [2:0]  sel_i,      // 0 add,1 and,2 andnot,3 asr,4 bitgen,5 sub
  output reg  [31:0] result_o,   // Result value
  output reg  [3:0]  flags_o     // Candidate {n,v,z,c}
);
  reg [32:0] wide;
  always @* begin
    wide     = 33'h000000000;
    result_o = 32'h00000000;
    case (sel_i)
      3'h0: begin
        wide     = {1'b0, a_i} + {1'b0, b_i};
        result_o = wide[31:0];
      end
      3'h1: result_o = a_i & b_i;
      3'h2: result_o = a_i & ~b_i;
      3'h3: result_o = $signed(a_i) >>> b_i[4:0];
      3'h4: result_o = 32'h00000001 << b_i[4:0];
      default: begin
        // Borrow is the inverse of the carry out of a + ~b + 1
        wide     = {1'b0, a_i} + {1'b0, ~b_i} + 33'h000000001;
        result_o = wide[31:0];
      end
    endcase
    flags_o[`LSB_FLAG_N] = result_o[31];
    flags_o[`LSB_FLAG_Z] = (result_o == 32'h00000000);
    if (sel_i == 3'h0) begin
      flags_o[`LSB_FLAG_V] = (a_i[31] == b_i[31]) && (result_o[31] != a_i[31]);
      flags_o[`LSB_FLAG_C] = wide[32];
    end else begin
      flags_o[`LSB_FLAG_V] = (a_i[31] != b_i[31]) && (result_o[31] != a_i[31]);
      flags_o[`LSB_FLAG_C] = ~wide[32];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/lsb_branch.v ----
// Purpose: Branch target and return address arithmetic
// Assumes: Program counter holds the address of the executing instruction
// Notes:   Combinational
`include "lsb_regs.vh"
`default_nettype none
module lsb_branch (
  input  wire [31:0] pc_i,        // Current program counter
  input  wire [10:0] offset_i,    // Eleven-bit immediate
  input  wire [31:0] reg_i,       // Register call target, half-word scaled
  output wire [31:0] rel_o,       // Relative target
  output wire [31:0] abs_o,       // Register call target
  output wire [31:0] link_o       // Return value for the link register
);
  wire [31:0] sext;
  wire [31:0] plus4;
  assign sext   = {{21{offset_i[10]}}, offset_i};
  assign rel_o  = pc_i + ((sext + 32'h00000001) << 1);
  assign abs_o  = {reg_i[30:0], 1'b0};
  assign plus4  = pc_i + `LSB_RETURN_OFFSET;
  assign link_o = {1'b0, plus4[31:1]};
endmodule
`default_nettype wire

// ---- rtl/lsb_core.v ----
// Purpose: Execute stage for add-immediate, logic, shift, branch and compare ops
// Assumes: One instruction presented per cycle with instr_valid_i
// Notes:   Register file sits outside; this block issues at most one write per op
`include "lsb_regs.vh"
`default_nettype none
module lsb_core (
  input  wire        clk_i,          // 200 MHz core clock
  input  wire        reset_n_i,      // Synchronous reset, active low
  input  wire        ce_i,           // Clock enable, freezes all state when low
  input  wire        instr_valid_i,  // Instruction word valid
  input  wire [15:0] instr_i,        // Instruction word
  input  wire [31:0] ra_data_i,      // First register operand value
  input  wire [31:0] rb_data_i,      // Second register operand value
  output reg  [4:0]  ra_index_o,     // Unused echo of destination index
  output reg         wr_en_o,        // Register write pulse
  output reg  [4:0]  wr_index_o,     // Register write index
  output reg  [31:0] wr_data_o,      // Register write data
  output reg  [3:0]  flags_o,        // Condition flags {n,v,z,c}
  output reg  [31:0] pc_o,           // Program counter
  output reg  [10:0] prefix_o,       // Prefix constant register
  output reg         illegal_o       // Word not handled by this unit
);
  // Decode
  wire [5:0]  op6;
  wire [4:0]  five_bit_immediate;
  wire [4:0]  idx_a;
  wire [10:0] eleven_bit_immediate;
  assign op6   = instr_i[15:10];
  assign five_bit_immediate  = instr_i[9:5];
  assign idx_a = instr_i[4:0];
  assign eleven_bit_immediate = instr_i[10:0];

  wire is_add_immediate_op;
  wire is_and;
  wire is_and_not_op;
  wire is_asr_r;
  wire is_asr_i;
  wire is_bit_generate_op;
  wire is_br;
  wire is_bsr;
  wire is_cmp;
  wire is_compare_imm_op;
  wire is_pfx;
  wire is_call;
  assign is_add_immediate_op  = (op6 == `LSB_OP6_ADD_IMMEDIATE);
  assign is_and   = (op6 == `LSB_OP6_AND_REG) || (op6 == `LSB_OP6_AND_IMM);
  assign is_and_not_op  = (op6 == `LSB_OP6_AND_NOT_REG) || (op6 == `LSB_OP6_AND_NOT_IMM);
  assign is_asr_r = (op6 == `LSB_OP6_ASR_REG);
  assign is_asr_i = (op6 == `LSB_OP6_ASR_IMM);
  assign is_bit_generate_op  = (op6 == `LSB_OP6_BIT_GENERATE);
  // Bit 10 is the offset sign, so branches decode on five bits only
  assign is_br    = (instr_i[15:11] == `LSB_OP5_BRANCH);
  assign is_bsr   = (instr_i[15:11] == `LSB_OP5_BRANCH_SUB);
  assign is_cmp   = (op6 == `LSB_OP6_COMPARE_REG);
  assign is_compare_imm_op  = (op6 == `LSB_OP6_COMPARE_IMM);
  assign is_pfx   = (instr_i[15:11] == `LSB_OP5_PREFIX);
  assign is_call  = (instr_i[15:5] == `LSB_OP11_CALL);

  // Prefix pending flag selects the constant for the and and and-not forms
  reg prefixed;

  // Second operand: prefixed constant or register or raw immediate
  wire [31:0] k_const;
  wire [31:0] imm_const;
  assign k_const   = {16'h0000, prefix_o, five_bit_immediate};
  assign imm_const = {27'h0000000, five_bit_immediate};

  reg  [31:0] b_op;
  reg  [2:0]  alu_sel;
  always @* begin
    b_op    = rb_data_i;
    alu_sel = 3'h1;
    if (is_add_immediate_op) begin
      b_op    = k_const;
      alu_sel = 3'h0;
    end else if (is_and) begin
      b_op    = prefixed ? k_const : rb_data_i;
      alu_sel = 3'h1;
    end else if (is_and_not_op) begin
      b_op    = prefixed ? k_const : rb_data_i;
      alu_sel = 3'h2;
    end else if (is_asr_r) begin
      b_op    = rb_data_i;
      alu_sel = 3'h3;
    end else if (is_asr_i) begin
      b_op    = imm_const;
      alu_sel = 3'h3;
    end else if (is_bit_generate_op) begin
      b_op    = imm_const;
      alu_sel = 3'h4;
    end else if (is_cmp) begin
      b_op    = rb_data_i;
      alu_sel = 3'h5;
    end else if (is_compare_imm_op) begin
      b_op    = k_const;
      alu_sel = 3'h5;
    end
  end

  wire [31:0] alu_res;
  wire [3:0]  alu_flags;
  lsb_alu u_alu (
    .a_i      (ra_data_i),
    .b_i      (b_op),
    .sel_i    (alu_sel),
    .result_o (alu_res),
    .flags_o  (alu_flags)
  );

  wire [31:0] rel_target;
  wire [31:0] abs_target;
  wire [31:0] link_value;
  lsb_branch u_branch (
    .pc_i     (pc_o),
    .offset_i (eleven_bit_immediate),
    .reg_i    (ra_data_i),
    .rel_o    (rel_target),
    .abs_o    (abs_target),
    .link_o   (link_value)
  );

  // Delay slot: a taken transfer is parked and applied after the next instruction
  reg        slot_pending;
  reg [31:0] slot_target;

  reg        next_wr_en;
  reg [4:0]  next_wr_index;
  reg [31:0] next_wr_data;
  reg [3:0]  next_flags;
  reg [31:0] next_pc;
  reg [10:0] next_prefix;
  reg        next_prefixed;
  reg        next_slot_pending;
  reg [31:0] next_slot_target;
  reg        next_illegal;

  always @* begin
    next_wr_en        = 1'b0;
    next_wr_index     = idx_a;
    next_wr_data      = alu_res;
    next_flags        = flags_o;
    next_pc           = pc_o + 32'h00000002;
    next_prefix       = `LSB_PREFIX_RESET;
    next_prefixed     = 1'b0;
    next_slot_pending = 1'b0;
    next_slot_target  = slot_target;
    next_illegal      = 1'b0;
    if (slot_pending) begin
      next_pc = slot_target;
    end
    if (is_pfx) begin
      next_prefix   = eleven_bit_immediate;
      next_prefixed = 1'b1;
    end else if (is_add_immediate_op) begin
      next_wr_en = 1'b1;
      next_flags = alu_flags;
    end else if (is_and || is_and_not_op) begin
      next_wr_en                = 1'b1;
      next_flags[`LSB_FLAG_N]   = alu_flags[`LSB_FLAG_N];
      next_flags[`LSB_FLAG_Z]   = alu_flags[`LSB_FLAG_Z];
    end else if (is_asr_r || is_asr_i || is_bit_generate_op) begin
      next_wr_en = 1'b1;
    end else if (is_cmp || is_compare_imm_op) begin
      next_flags = alu_flags;
    end else if (is_br || is_bsr) begin
      next_slot_pending = 1'b1;
      next_slot_target  = rel_target;
      if (is_bsr) begin
        next_wr_en    = 1'b1;
        next_wr_index = `LSB_LINK_INDEX;
        next_wr_data  = link_value;
      end
    end else if (is_call) begin
      next_slot_pending = 1'b1;
      next_slot_target  = abs_target;
      next_wr_en        = 1'b1;
      next_wr_index     = `LSB_LINK_INDEX;
      next_wr_data      = link_value;
    end else begin
      next_illegal = 1'b1;
    end
    // A transfer in a delay slot is not supported; the earlier one wins
    if (slot_pending) begin
      next_slot_pending = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ra_index_o   <= 5'h00;
      wr_en_o      <= 1'b0;
      wr_index_o   <= 5'h00;
      wr_data_o    <= 32'h00000000;
      flags_o      <= `LSB_FLAGS_RESET;
      pc_o         <= `LSB_PC_RESET;
      prefix_o     <= `LSB_PREFIX_RESET;
      prefixed     <= 1'b0;
      slot_pending <= 1'b0;
      slot_target  <= 32'h00000000;
      illegal_o    <= 1'b0;
    end else if (ce_i) begin
      wr_en_o <= 1'b0;
      if (instr_valid_i) begin
        ra_index_o   <= idx_a;
        wr_en_o      <= next_wr_en;
        wr_index_o   <= next_wr_index;
        wr_data_o    <= next_wr_data;
        flags_o      <= next_flags;
        pc_o         <= next_pc;
        prefix_o     <= next_prefix;
        prefixed     <= next_prefixed;
        slot_pending <= next_slot_pending;
        slot_target  <= next_slot_target;
        illegal_o    <= next_illegal;
      end
    end
  end
endmodule
`default_nettype wire

// ---- shared/lsb_regs.vh ----
// Purpose: Opcodes, flag positions and constants of the logic/shift/branch unit
// Assumes: 16-bit instruction words, 32-bit data
// Notes:   Opcode fields are compared against the top bits of the word
`ifndef LSB_REGS_VH
`define LSB_REGS_VH

// Six-bit major opcodes, bits 15..10
`define LSB_OP6_ADD_IMMEDIATE  6'h01
`define LSB_OP6_COMPARE_REG    6'h04
`define LSB_OP6_COMPARE_IMM    6'h05
`define LSB_OP6_ASR_REG        6'h0a
`define LSB_OP6_ASR_IMM        6'h0b
`define LSB_OP6_AND_REG        6'h10
`define LSB_OP6_AND_NOT_REG    6'h11
`define LSB_OP6_AND_IMM        6'h18
`define LSB_OP6_AND_NOT_IMM    6'h19
`define LSB_OP6_BIT_GENERATE   6'h1b
// Five-bit opcodes, bits 15..11; branches keep all eleven offset bits
`define LSB_OP5_BRANCH         5'h10
`define LSB_OP5_BRANCH_SUB     5'h11
`define LSB_OP5_PREFIX         5'h13
// Eleven-bit register call opcode, bits 15..5
`define LSB_OP11_CALL          11'h3ff

// Flag vector positions {n,v,z,c}
`define LSB_FLAG_N             3
`define LSB_FLAG_V             2
`define LSB_FLAG_Z             1
`define LSB_FLAG_C             0

// Reset values
`define LSB_PC_RESET           32'h00000000
`define LSB_FLAGS_RESET        4'h0
`define LSB_PREFIX_RESET       11'h000

// Return address distance and link register index
`define LSB_RETURN_OFFSET      32'h00000004
`define LSB_LINK_INDEX         5'h0f

`endif
